// file: rps_serializer.sv
`timescale 1ns/1ps
`default_nettype none
// Function
// R01: Reset gives 18-bit, no dither, 6X clock.
// R02: Wide mode: 8X clock, 32-bit payload.
// R03: Wide payload ends with two low bits.
// R04: Dither reduces to 18 bits, 6X.
// R05: Narrow mode sends colour bits 7 to 2.
// R06: Source ties unused low colour bits.
// R07: Order: colour, syncs, valid, parity, sequence.
// R08: Lanes change on both serial clock edges.
// R09: Bit period is pixel/12 or pixel/16.
// R10: Parity makes total ones odd.
// R11: Inputs captured on pixel clock rising edge.
// R12: Syncs and valid forwarded unchanged.
// R13: OFF phase drives all outputs low.
// R14: Outputs static until multiplier lock.
// R15: Phases OFF, link-up, active; legal steps.
// R16: Stopped pixel clock resets, then relock.
// R17: Source pixel clock 5 to 30 MHz.
// R18: Sequence count steps every sent payload.
// R19: Source supplies vertical sync for dither.
// R20: Payload split evenly over two lanes.
// R21: Frame-synchronous dither, eight to six bits.
module rps_serializer
  import rps_pkg::*;
#(
  parameter int unsigned LOCK_PCLK = LOCK_PCLK_DEF
)(
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       pixel_clk_i,
  input  wire logic [7:0] red_i,
  input  wire logic [7:0] green_i,
  input  wire logic [7:0] blue_i,
  input  wire logic       vertical_sync_i,
  input  wire logic       horizontal_sync_i,
  input  wire logic       pixel_valid_i,
  input  wire logic       link_enable_i,
  input  wire logic       wide_colour_i,
  input  wire logic       dither_enable_i,
  output logic            forwarded_serial_clock_o,
  output logic            serial_data_lane0_o,
  output logic            serial_data_lane1_o,
  output logic [1:0]      link_phase_o,
  output logic            pixel_drop_o
);
  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  localparam int unsigned SYNC_W = 31;

  logic [SYNC_W-1:0] pin_raw;      // All asynchronous pins
  logic [SYNC_W-1:0] pin_s1_r;     // First stage, read only by stage two
  logic [SYNC_W-1:0] pin_s2_r;     // Second stage, safe to use
  logic              pclk_s3_r;    // Delayed pixel clock for edges

  assign pin_raw = {pixel_clk_i, red_i, green_i, blue_i, vertical_sync_i,
                    horizontal_sync_i, pixel_valid_i, link_enable_i,
                    wide_colour_i, dither_enable_i};

  // Two flops on every pin
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pin_s1_r  <= '0;
      pin_s2_r  <= '0;
      pclk_s3_r <= 1'b0;
    end else begin
      pin_s1_r  <= pin_raw;
      pin_s2_r  <= pin_s1_r;
      pclk_s3_r <= pin_s2_r[30];
    end
  end

  logic       pclk_rise;           // Pixel clock rising edge seen
  logic [7:0] red_s;               // Synchronised colour and controls
  logic [7:0] green_s;
  logic [7:0] blue_s;
  logic [2:0] ctl_s;               // Vertical, horizontal, valid
  logic       en_s;
  logic       wide_s;
  logic       dith_s;

  assign pclk_rise = pin_s2_r[30] & ~pclk_s3_r; // R11
  assign red_s     = pin_s2_r[29:22];
  assign green_s   = pin_s2_r[21:14];
  assign blue_s    = pin_s2_r[13:6];
  assign ctl_s     = pin_s2_r[5:3];
  assign en_s      = pin_s2_r[2];
  assign wide_s    = pin_s2_r[1];
  assign dith_s    = pin_s2_r[0];

  // ---------------------------------------------------------------
  // Pixel period measure and stop detect
  // ---------------------------------------------------------------
  logic [PER_W-1:0]   per_cnt_r;   // Cycles since last pixel edge
  logic [PER_W-1:0]   period_r;    // Last measured pixel period, 0 = unknown
  logic [PER_W+2:0]   stop_lim;    // Silence that counts as stopped
  logic               stop_det;    // Pixel clock has stopped

  assign stop_lim = (PER_W+3)'(period_r) * (PER_W+3)'(STOP_PCLK);
  assign stop_det = (period_r != '0) && ((PER_W+3)'(per_cnt_r) >= stop_lim); // R16

  // Count cycles between rising edges; forget the period on a stop
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      per_cnt_r <= '0;
      period_r  <= '0;
    end else if (stop_det) begin
      per_cnt_r <= '0;
      period_r  <= '0; // R16
    end else if (pclk_rise) begin
      per_cnt_r <= PER_W'(1);
      period_r  <= per_cnt_r;
    end else if (per_cnt_r != '1) begin
      per_cnt_r <= per_cnt_r + 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Link phase machine
  // ---------------------------------------------------------------
  rps_phase_e         phase_r;     // Current phase
  rps_phase_e         phase_nxt;   // Next phase
  logic [LOCK_W-1:0]  lock_cnt_r;  // Pixel edges seen while locking
  logic               locked;      // Multiplier lock reached

  assign locked = pclk_rise && (lock_cnt_r == LOCK_W'(LOCK_PCLK - 1)); // R14

  // Next phase
  always_comb begin
    phase_nxt = phase_r;
    case (phase_r)
      PH_OFF: begin
        if (en_s && pclk_rise && !stop_det) begin
          phase_nxt = PH_LINKUP; // R15
        end
      end
      PH_LINKUP: begin
        if (!en_s || stop_det) begin
          phase_nxt = PH_OFF; // R15
        end else if (locked) begin
          phase_nxt = PH_ACTIVE; // R14
        end
      end
      PH_ACTIVE: begin
        if (!en_s || stop_det) begin
          phase_nxt = PH_OFF; // R16
        end
      end
      default: begin
        phase_nxt = PH_OFF;
      end
    endcase
  end

  // Phase register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      phase_r <= PH_OFF;
    end else begin
      phase_r <= phase_nxt;
    end
  end

  // Lock counter runs only in link-up
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lock_cnt_r <= '0;
    end else if (phase_r != PH_LINKUP) begin
      lock_cnt_r <= '0;
    end else if (pclk_rise) begin
      lock_cnt_r <= lock_cnt_r + 1'b1;
    end
  end

  assign link_phase_o = phase_r;

  // ---------------------------------------------------------------
  // Mode configuration, changed only while off
  // ---------------------------------------------------------------
  logic wide_r;                    // 24-bit input, 8X clock unless dithering is on
  logic dith_r;                    // Dither 24 to 18 bits

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wide_r <= WIDE_RST; // R01
      dith_r <= DITHER_RST; // R01
    end else if (phase_r == PH_OFF) begin
      wide_r <= wide_s;
      dith_r <= dith_s;
    end
  end

  logic send_wide;                 // 32-bit payload in use
  assign send_wide = wide_r & ~dith_r; // R02

  // ---------------------------------------------------------------
  // Dither pattern state
  // ---------------------------------------------------------------
  logic [1:0] frame_r;             // Frame count, steps on vertical sync
  logic [1:0] col_r;               // Pixel position within frame, modulo 4
  logic       vsync_prev_r;        // Vertical sync at previous pixel
  logic [1:0] offset;              // Dither offset for this pixel

  assign offset = frame_r + col_r;

  // Advance on each pixel; new frame steps the frame count and restarts the column
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      frame_r      <= '0;
      col_r        <= '0;
      vsync_prev_r <= 1'b0;
    end else if (phase_r != PH_ACTIVE) begin
      frame_r      <= '0;
      col_r        <= '0;
      vsync_prev_r <= 1'b0;
    end else if (pclk_rise) begin
      vsync_prev_r <= ctl_s[2];
      if (ctl_s[2] && !vsync_prev_r) begin
        frame_r <= frame_r + 1'b1; // R21
        col_r   <= '0;
      end else begin
        col_r <= col_r + 1'b1;
      end
    end
  end

  // Round eight bits to six with an offset, saturating at full scale
  function automatic logic [CH_NARROW-1:0] dith8(input logic [CH_W-1:0] c, input logic [1:0] off);
    logic [CH_W:0] sum;
    sum = {1'b0, c} + {7'h00, off};
    dith8 = sum[CH_W] ? '1 : sum[CH_W-1:2]; // R21
  endfunction

  // ---------------------------------------------------------------
  // Payload build and capture
  // ---------------------------------------------------------------
  rps_stream_if #(.W(PAY_W)) cap_if ();
  rps_stream_if #(.W(PAY_W)) ser_if ();

  logic [SEQ_W-1:0] seq_r;         // Payload sequence count
  logic [5:0]       r6;            // Narrow colour channels
  logic [5:0]       g6;
  logic [5:0]       b6;
  logic             par_wide;      // Parity of the wide payload
  logic             par_nar;       // Parity of the narrow payload
  logic [PAY_W-1:0] word;          // Payload for the current pixel
  logic [PAY_W-1:0] cap_word_r;    // Captured payload
  logic             cap_valid_r;   // Captured payload waits for the FIFO
  logic             cap_push;      // FIFO took the payload

  assign r6 = dith_r ? dith8(red_s, offset) : red_s[7:2]; // R05
  assign g6 = dith_r ? dith8(green_s, offset + 2'h1) : green_s[7:2]; // R04
  assign b6 = dith_r ? dith8(blue_s, offset + 2'h2) : blue_s[7:2]; // R04

  assign par_wide = ~^{red_s, green_s, blue_s, ctl_s, seq_r}; // R10
  assign par_nar  = ~^{r6, g6, b6, ctl_s, seq_r}; // R10
  assign word = send_wide ? {red_s, green_s, blue_s, ctl_s, par_wide, seq_r, RSV_BITS} // R03
                          : {r6, g6, b6, ctl_s, par_nar, seq_r, NAR_PAD}; // R07

  assign cap_if.data  = cap_word_r;
  assign cap_if.valid = cap_valid_r;
  assign cap_push     = cap_valid_r & cap_if.ready;

  // Hold one pixel until the FIFO accepts it; a newer pixel replaces it
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cap_word_r  <= '0;
      cap_valid_r <= 1'b0;
    end else if (phase_r != PH_ACTIVE) begin
      cap_valid_r <= 1'b0;
    end else if (pclk_rise) begin
      cap_word_r  <= word; // R12
      cap_valid_r <= 1'b1; // R11
    end else if (cap_push) begin
      cap_valid_r <= 1'b0;
    end
  end

  // Drop flag when a waiting pixel is overwritten
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pixel_drop_o <= 1'b0;
    end else begin
      pixel_drop_o <= (phase_r == PH_ACTIVE) && pclk_rise && cap_valid_r && !cap_if.ready;
    end
  end

  // Sequence steps with each payload handed on
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      seq_r <= '0;
    end else if (phase_r != PH_ACTIVE) begin
      seq_r <= '0; // R16
    end else if (pclk_rise && (!cap_valid_r || cap_if.ready)) begin
      seq_r <= seq_r + 1'b1; // R18
    end
  end

  rps_fifo #(.W(PAY_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk  (clk),
    .nrst (nrst),
    .clr  (phase_r != PH_ACTIVE),
    .wr   (cap_if.snk),
    .rd   (ser_if.src)
  );

  // ---------------------------------------------------------------
  // Bit rate generator: steps per lane spread over the pixel period
  // ---------------------------------------------------------------
  logic [4:0]       steps;         // Bit steps per lane per pixel
  logic [PER_W:0]   acc_r;         // Fractional accumulator
  logic [PER_W:0]   acc_sum;
  logic             bit_en;        // One lane bit period elapsed

  assign steps   = send_wide ? STEPS_WIDE : STEPS_NAR; // R09
  assign acc_sum = acc_r + {12'h000, steps};
  assign bit_en  = (phase_r == PH_ACTIVE) && (acc_sum >= {1'b0, period_r}); // R09

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      acc_r <= '0;
    end else if (phase_r != PH_ACTIVE) begin
      acc_r <= '0;
    end else if (bit_en) begin
      acc_r <= ((acc_sum - {1'b0, period_r}) >= {1'b0, period_r}) ? '0
                                                                  : acc_sum - {1'b0, period_r};
    end else begin
      acc_r <= acc_sum;
    end
  end

  // ---------------------------------------------------------------
  // Lane shifter and output drivers
  // ---------------------------------------------------------------
  logic [PAY_W-1:0] shift_r;       // Payload being sent, MSB first
  logic [4:0]       left_r;        // Bit steps left in this payload

  assign ser_if.ready = (left_r == '0);

  // Load a payload when idle, send two bits per step
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      shift_r <= '0;
      left_r  <= '0;
    end else if (phase_r != PH_ACTIVE) begin
      left_r <= '0;
    end else if (ser_if.ready && ser_if.valid) begin
      shift_r <= bit_en ? {ser_if.data[PAY_W-3:0], 2'b00} : ser_if.data; // First pair leaves now, no step lost
      left_r  <= bit_en ? steps - 5'h01 : steps;
    end else if (bit_en && (left_r != '0)) begin
      shift_r <= {shift_r[PAY_W-3:0], 2'b00}; // R20
      left_r  <= left_r - 1'b1;
    end
  end

  // Pins: low when off, static high while locking, streaming when active
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      forwarded_serial_clock_o <= 1'b0;
      serial_data_lane0_o      <= 1'b0;
      serial_data_lane1_o      <= 1'b0;
    end else begin
      case (phase_r)
        PH_LINKUP: begin
          forwarded_serial_clock_o <= 1'b1; // R14
          serial_data_lane0_o      <= 1'b1;
          serial_data_lane1_o      <= 1'b1;
        end
        PH_ACTIVE: begin
          if (bit_en) begin
            forwarded_serial_clock_o <= ~forwarded_serial_clock_o; // R08
            serial_data_lane0_o      <= (left_r != '0) ? shift_r[PAY_W-1] // R20
                                                       : (ser_if.valid & ser_if.data[PAY_W-1]);
            serial_data_lane1_o      <= (left_r != '0) ? shift_r[PAY_W-2]
                                                       : (ser_if.valid & ser_if.data[PAY_W-2]);
          end
        end
        default: begin
          forwarded_serial_clock_o <= 1'b0; // R13
          serial_data_lane0_o      <= 1'b0;
          serial_data_lane1_o      <= 1'b0;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  chk_off_pins_low: assert property ((phase_r == PH_OFF)[*2] |-> // R13
    !forwarded_serial_clock_o && !serial_data_lane0_o && !serial_data_lane1_o)
    else $error("pins not low while off");
  chk_linkup_static: assert property ((phase_r == PH_LINKUP)[*2] |-> // R14
    forwarded_serial_clock_o && serial_data_lane0_o && serial_data_lane1_o)
    else $error("pins not static while locking");
  chk_phase_steps: assert property (phase_r == PH_OFF |=> phase_r != PH_ACTIVE) // R15
    else $error("off jumped straight to active");
  chk_clock_only_active: assert property ($changed(forwarded_serial_clock_o) && // R15
    $past(phase_r) != PH_OFF && $past(phase_r, 2) != PH_OFF |-> $past(phase_r) == PH_ACTIVE)
    else $error("serial clock toggled outside active");
  chk_lane_with_clock: assert property ($past(phase_r) == PH_ACTIVE && // R08
    ($changed(serial_data_lane0_o) || $changed(serial_data_lane1_o)) |-> $changed(forwarded_serial_clock_o))
    else $error("lane changed without a serial clock edge");
  chk_parity_odd: assert property (cap_valid_r |-> ^cap_word_r) // R10
    else $error("payload ones count not odd");
  chk_seq_step: assert property (phase_r == PH_ACTIVE && pclk_rise && !cap_valid_r && // R18
    phase_nxt == PH_ACTIVE |=> seq_r == $past(seq_r) + 2'h1)
    else $error("sequence count did not step");
  chk_stop_resets: assert property (stop_det |=> phase_r == PH_OFF ##1 phase_r != PH_ACTIVE) // R16
    else $error("stopped pixel clock did not reset link");
  chk_mode_while_off: assert property ($changed(wide_r) || $changed(dith_r) |-> // R01
    $past(phase_r) == PH_OFF)
    else $error("mode changed while link running");
  chk_narrow_colour: assert property (pclk_rise && phase_r == PH_ACTIVE && !wide_r && // R05
    !dith_r |=> cap_word_r[31:26] == $past(red_s[7:2]) && cap_word_r[7:0] == 8'h00)
    else $error("narrow payload colour wrong");
  chk_wide_pad: assert property (cap_valid_r && send_wide |-> cap_word_r[1:0] == 2'h0) // R03
    else $error("wide payload padding not low");

  cov_reach_active: cover property (phase_r == PH_LINKUP ##1 phase_r == PH_ACTIVE);
  cov_stop_restart: cover property (stop_det ##[1:200] phase_r == PH_LINKUP);
  cov_wide_push: cover property (cap_push && send_wide);
  cov_dither_push: cover property (cap_push && dith_r);
endmodule
`default_nettype wire

// file: rps_pkg.sv
// ---------------------------------------------------------------
// Shared constants of the pixel link serializer
// ---------------------------------------------------------------
package rps_pkg;

  // ---------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ        = 40_000_000; // System clock rate
  localparam int unsigned STOP_PCLK     = 4;          // Pixel periods of silence that reset the link
  localparam int unsigned LOCK_PCLK_DEF = 1024;       // Pixel clocks for the multiplier to lock
  localparam int unsigned PER_W         = 16;         // Width of the pixel period counter
  localparam int unsigned LOCK_W        = 11;         // Width of the lock counter

  // ---------------------------------------------------------------
  // Payload layout
  // ---------------------------------------------------------------
  localparam int unsigned PAY_W      = 32;            // Widest payload, 24-bit colour mode
  localparam int unsigned LANE_N     = 2;             // Data lanes
  localparam int unsigned CH_W       = 8;             // Input bits per colour channel
  localparam int unsigned CH_NARROW  = 6;             // Sent bits per channel in narrow modes
  localparam int unsigned SEQ_W      = 2;             // Payload sequence count width
  localparam logic [4:0]  STEPS_WIDE = 5'h10;         // Bit steps per lane, 32-bit payload
  localparam logic [4:0]  STEPS_NAR  = 5'h0c;         // Bit steps per lane, 24-bit payload
  localparam logic [1:0]  RSV_BITS   = 2'h0;          // Padding of the wide payload, always low
  localparam logic [7:0]  NAR_PAD    = 8'h00;         // Unused tail of the narrow payload

  // ---------------------------------------------------------------
  // Buffering
  // ---------------------------------------------------------------
  localparam int unsigned FIFO_DEPTH = 8;             // Payload words held between the domains of work

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic WIDE_RST   = 1'b0;                 // 18-bit input after reset
  localparam logic DITHER_RST = 1'b0;                 // Dithering off after reset

  // Link phases
  typedef enum logic [1:0] {
    PH_OFF    = 2'b00,
    PH_LINKUP = 2'b01,
    PH_ACTIVE = 2'b10
  } rps_phase_e;

endpackage

// file: rps_stream_if.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// Valid/ready word stream between the serializer parts
// ---------------------------------------------------------------
interface rps_stream_if #(
  parameter int unsigned W = 32
);
  logic [W-1:0] data;   // Payload word
  logic         valid;  // Word offered
  logic         ready;  // Word taken

  // Producer side
  modport src (output data, output valid, input ready);
  // Consumer side
  modport snk (input data, input valid, output ready);
endinterface
`default_nettype wire

// file: rps_fifo.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// Synchronous word FIFO with valid/ready on both sides
// ---------------------------------------------------------------
module rps_fifo
  import rps_pkg::*;
#(
  parameter int unsigned W     = PAY_W,
  parameter int unsigned DEPTH = FIFO_DEPTH
)(
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic clr,
  rps_stream_if.snk wr,
  rps_stream_if.src rd
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];   // Word storage
  logic [AW:0]  wptr_r;        // Write pointer with wrap bit
  logic [AW:0]  rptr_r;        // Read pointer with wrap bit
  logic         full;          // No room left
  logic         empty;         // Nothing stored
  logic         push;          // Word accepted
  logic         pop;           // Word delivered

  assign full     = (wptr_r[AW-1:0] == rptr_r[AW-1:0]) && (wptr_r[AW] != rptr_r[AW]);
  assign empty    = (wptr_r == rptr_r);
  assign wr.ready = ~full;
  assign rd.valid = ~empty;
  assign rd.data  = mem[rptr_r[AW-1:0]];
  assign push     = wr.valid & ~full;
  assign pop      = rd.ready & ~empty;

  // Storage write, no reset needed on data
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wptr_r[AW-1:0]] <= wr.data;
    end
  end

  // Pointers, flushed by clr
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wptr_r <= '0;
      rptr_r <= '0;
    end else if (clr) begin
      wptr_r <= '0;
      rptr_r <= '0;
    end else begin
      if (push) begin
        wptr_r <= wptr_r + 1'b1;
      end
      if (pop) begin
        rptr_r <= rptr_r + 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  chk_fifo_no_overrun: assert property (@(posedge clk) disable iff (!nrst)
    full && !pop && !clr |=> full)
    else $error("fifo lost its full state without a read");
endmodule
`default_nettype wire

// file: rps_deser_model.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// Far-end deserializer model: rebuilds payload words from lanes
// ---------------------------------------------------------------
module rps_deser_model
  import rps_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        fsc,
  input  wire logic        lane0,
  input  wire logic        lane1,
  input  wire logic [1:0]  phase,
  input  wire logic        wide,
  output logic [31:0]      word,
  output logic             word_stb
);
  logic        fsc_r;  // Last seen serial clock level
  logic [4:0]  step_r; // Bit pairs taken in this payload
  logic [31:0] sh_r;   // Assembly shift register
  // Take one bit pair on every serial clock edge; realign outside active
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      fsc_r <= 1'b0;
      step_r <= '0;
      sh_r <= '0;
      word <= '0;
      word_stb <= 1'b0;
    end else begin
      fsc_r <= fsc;
      word_stb <= 1'b0;
      if (phase != PH_ACTIVE) begin
        step_r <= '0;
      end else if (fsc != fsc_r) begin
        sh_r <= {sh_r[29:0], lane0, lane1};
        if (step_r == (wide ? STEPS_WIDE : STEPS_NAR) - 5'h01) begin
          word <= {sh_r[29:0], lane0, lane1};
          word_stb <= (wide ? {sh_r[29:0], lane0, lane1} : {8'h00, sh_r[21:0], lane0, lane1}) != 32'h0; // Idle pairs
          step_r <= '0;
        end else begin
          step_r <= step_r + 5'h01;
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: rps_serializer_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module rps_serializer_tb_top
  import rps_pkg::*;
;
  logic        clk = 0, nrst = 0, pclk = 0, prun = 0;  // Clocks, reset, pixel clock gate
  logic [7:0]  red = 0, green = 0, blue = 0;           // Colour pins
  logic        vs = 0, hs = 0, de = 0, en = 0;         // Controls and link enable
  logic        wide = 0, dith = 0, fsc_q = 0;          // Mode pins, last serial clock
  logic        fsc, l0, l1, drop, stb;                 // Design and model outputs
  logic [1:0]  ph;                                     // Link phase
  logic [31:0] word;                                   // Rebuilt payload
  int          n_mismatch = 0, num_checks = 0;         // Verdict counters
  int          phalf = 300, tog = 0, drops = 0;        // Pixel half period, counters
  always #12.5 clk = ~clk;
  // Pixel clock stands still while prun is low
  always #(phalf) if (prun) pclk = ~pclk;
  // Count serial clock edges and dropped pixels
  always @(posedge clk) begin
    fsc_q <= fsc;
    if (fsc !== fsc_q) tog <= tog + 1;
    if (drop === 1'b1) drops <= drops + 1;
  end
  rps_serializer #(.LOCK_PCLK(4)) u_dut (.clk(clk), .nrst(nrst), .pixel_clk_i(pclk), .red_i(red),
    .green_i(green), .blue_i(blue), .vertical_sync_i(vs), .horizontal_sync_i(hs), .pixel_valid_i(de),
    .link_enable_i(en), .wide_colour_i(wide), .dither_enable_i(dith), .forwarded_serial_clock_o(fsc),
    .serial_data_lane0_o(l0), .serial_data_lane1_o(l1), .link_phase_o(ph), .pixel_drop_o(drop));
  rps_deser_model u_model (.clk(clk), .nrst(nrst), .fsc(fsc), .lane0(l0), .lane1(l1), .phase(ph),
    .wide(wide & ~dith), .word(word), .word_stb(stb));
  task cmp(input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask
  task tally_and_finish;
    if (n_mismatch == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Bounded wait for a link phase
  task wait_ph(input logic [1:0] p);
    int i;
    for (i = 0; i < 4000 && ph !== p; i++) @(posedge clk);
    if (ph !== p) begin
      cmp({30'h0, p}, {30'h0, ph});
      tally_and_finish();
    end
  endtask
  // Set mode while off, enable, check static link-up level, reach active
  task start(input logic w, input logic d, input logic [26:0] px);
    @(posedge clk);
    en <= 1'b0;
    wide <= w;
    dith <= d;
    {red, green, blue, vs, hs, de} <= px;
    prun = 1'b1;
    wait_ph(PH_OFF);
    @(posedge clk);
    en <= 1'b1;
    wait_ph(PH_LINKUP);
    repeat (2) @(posedge clk);
    cmp(32'h7, {29'h0, fsc, l0, l1});
    wait_ph(PH_ACTIVE);
  endtask
  // Stream six pixels, judge each word, then the serial clock rate
  task stream(input logic w, input logic d, input logic [26:0] px);
    int i, k, t0, s;
    logic ww;
    logic [31:0] e, m;
    ww = w & ~d;
    s = ww ? 16 : 12;
    m = d ? 32'h3b : (ww ? 32'hffffffef : 32'h00fffffb);
    start(w, d, px);
    for (k = 0; k < 6; k++) begin
      for (i = 0; i < 2000 && stb !== 1'b1; i++) @(posedge clk);
      cmp(32'h1, {31'h0, stb});
      cmp(32'h1, {31'h0, ^(word & (ww ? 32'hffffffff : 32'h00ffffff))});
      e = ww ? {px[26:3], px[2:0], 1'b0, k[1:0], 2'b00}
             : {8'h0, px[26:21], px[18:13], px[10:5], px[2:0], 1'b0, k[1:0]};
      cmp(e & m, word & m);
      @(posedge clk);
    end
    t0 = tog;
    repeat (4 * 2 * phalf / 25) @(posedge clk);
    cmp(32'h1, {31'h0, (tog - t0 >= 4 * s - 1) && (tog - t0 <= 4 * s + 1)});
  endtask
  // Stop the pixel clock in active, then restart it
  task clk_stop;
    start(1'b0, 1'b0, {24'h123456, 3'b100});
    prun = 1'b0;
    wait_ph(PH_OFF);
    @(posedge clk);
    cmp(32'h0, {29'h0, fsc, l0, l1});
    prun = 1'b1;
    wait_ph(PH_LINKUP);
    wait_ph(PH_ACTIVE);
    cmp({30'h0, PH_ACTIVE}, {30'h0, ph});
  endtask
  // Pixels faster than the lanes: buffer fills and refuses, then link off
  task overflow;
    int i;
    phalf = 100;
    start(1'b0, 1'b0, {24'hfedcba, 3'b001});
    for (i = 0; i < 3000 && drops == 0; i++) @(posedge clk);
    cmp(32'h1, {31'h0, drops > 0});
    @(posedge clk);
    en <= 1'b0;
    wait_ph(PH_OFF);
    @(posedge clk);
    cmp(32'h0, {29'h0, fsc, l0, l1});
  endtask
  initial begin
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    cmp(32'h0, {27'h0, fsc, l0, l1, ph});
    stream(1'b0, 1'b0, {8'ha7, 8'h5e, 8'hc3, 3'b101});
    stream(1'b1, 1'b0, {8'h3c, 8'h81, 8'hf6, 3'b010});
    stream(1'b1, 1'b1, {8'h9b, 8'h24, 8'h6d, 3'b111});
    cmp(32'h0, drops);
    clk_stop();
    overflow();
    tally_and_finish();
  end
endmodule
`default_nettype wire
